// ==== core/opct_edge_filter.sv ====
// trigger pin synchroniser, two-sample noise filter and valid-edge detector
// assumes pin is asynchronous to mclk; sample_en comes from mclk logic
`timescale 1ns/1ps
module opct_edge_filter
	import opct_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	opct_edge_if.filt eif
);
	logic sync1_r;
	logic sync2_r;
	logic smp_r;
	logic lvl_r;
	logic seen_r;
	logic edge_r;
	logic accept;
	logic want;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
		end else begin
			sync1_r <= eif.pin;
			sync2_r <= sync1_r;
		end
	end

	// a new level counts only after two equal samples in a row
	assign accept = eif.run && eif.sample_en && (smp_r == sync2_r) && (sync2_r != lvl_r);

	always_comb begin
		case (opct_edge_e'(eif.edge_sel))
			EDGE_FALL: want = !sync2_r;
			EDGE_RISE: want = sync2_r;
			EDGE_BOTH: want = 1'b1;
			default: want = 1'b0;
		endcase
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			smp_r <= 1'b0;
		end else if (eif.sample_en || !eif.run) begin
			smp_r <= sync2_r;
		end
	end

	// level starts low: a pin already high shows a rising edge at first enable only;
	// once enabled, a stopped timer keeps tracking quietly so restarts see no edge
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			lvl_r <= 1'b0;
			seen_r <= 1'b0;
		end else begin
			if (eif.run) begin
				seen_r <= 1'b1;
			end
			if (accept || (!eif.run && seen_r)) begin
				lvl_r <= sync2_r;
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			edge_r <= 1'b0;
		end else begin
			edge_r <= accept && want;
		end
	end

	assign eif.valid_edge = edge_r;
endmodule

// ==== core/opct_edge_if.sv ====
// carrier between the timer core and one trigger-input edge filter
// assumes both ends sit on mclk
`timescale 1ns/1ps
interface opct_edge_if;
	import opct_pkg::*;
	logic pin;
	logic sample_en;
	logic run;
	logic [1:0] edge_sel;
	logic valid_edge;
	modport filt (input pin, input sample_en, input run, input edge_sel, output valid_edge);
	modport ctrl (output pin, output sample_en, output run, output edge_sel, input valid_edge);
endinterface

// ==== core/opct_pkg.sv ====
// constants, modes and types shared by the one-shot pulse / capture timer
// assumes a single clock domain (mclk) and an active-low asynchronous reset
package opct_pkg;

	// ---------------------------------------------------------------
	// widths and counter values
	// ---------------------------------------------------------------
	localparam int CNT_W = 16;
	typedef logic [CNT_W-1:0] opct_cnt_t;
	localparam opct_cnt_t CNT_ZERO = 16'h0000;
	localparam opct_cnt_t CNT_ONE = 16'h0001;
	localparam opct_cnt_t CNT_MAX = 16'hffff;

	// ---------------------------------------------------------------
	// operating modes, edge selections and prescaler settings
	// ---------------------------------------------------------------
	// order fixes the two-bit encoding: stop is the all-zero code
	typedef enum logic [1:0] {MODE_STOP, MODE_EDGE_CLR, MODE_FREE, MODE_MATCH_CLR} opct_mode_e;
	typedef enum logic [1:0] {EDGE_FALL, EDGE_RISE, EDGE_NONE, EDGE_BOTH} opct_edge_e;
	typedef enum logic [1:0] {SRC_DIV1, SRC_DIV2, SRC_DIV4, SRC_DIV8} opct_src_e;

	localparam int PRESC_W = 3;
	typedef logic [PRESC_W-1:0] opct_presc_t;
	localparam opct_presc_t PRESC_ZERO = 3'h0;
	localparam opct_presc_t PRESC_ONE = 3'h1;
	localparam opct_presc_t PRESC_LAST_DIV1 = 3'h0;
	localparam opct_presc_t PRESC_LAST_DIV2 = 3'h1;
	localparam opct_presc_t PRESC_LAST_DIV4 = 3'h3;
	localparam opct_presc_t PRESC_LAST_DIV8 = 3'h7;

	// ---------------------------------------------------------------
	// one-shot sequencing
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {OS_IDLE, OS_WAIT, OS_PULSE} opct_os_e;

endpackage

// ==== core/opct_prescaler.sv ====
// count-clock generator: rise and fall phase pulses of the selected count clock
// assumes run drops to zero whenever the timer is stopped
`timescale 1ns/1ps
module opct_prescaler
	import opct_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic run,
	input wire logic [1:0] src_sel,
	output logic rise,
	output logic fall
);
	opct_presc_t div_r;
	opct_presc_t last;
	opct_presc_t half;

	always_comb begin
		case (opct_src_e'(src_sel))
			SRC_DIV1: last = PRESC_LAST_DIV1;
			SRC_DIV2: last = PRESC_LAST_DIV2;
			SRC_DIV4: last = PRESC_LAST_DIV4;
			default: last = PRESC_LAST_DIV8;
		endcase
		// widen first: for the divide-by-eight setting last + 1 does not fit in three bits
		half = opct_presc_t'(({1'b0, last} + {1'b0, PRESC_ONE}) >> 1);
	end

	// divider is held at zero while stopped, so the first rise phase comes in the first running cycle
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			div_r <= PRESC_ZERO;
		end else if (!run || div_r == last) begin
			div_r <= PRESC_ZERO;
		end else begin
			div_r <= div_r + PRESC_ONE;
		end
	end

	assign rise = run && (div_r == PRESC_ZERO);
	assign fall = run && (div_r == (half & last));
endmodule

// ==== core/opct_top.sv ====
// 16-bit timer core: one-shot pulse output, capture/compare, overflow flag
// assumes control bits come from software logic on mclk; pins are asynchronous
//
// Function
// RL1: external trigger edge launches a one-shot pulse
// RL2: trigger edge: rising, falling or both
// RL3: trigger clears, starts counter; B match activates
// RL4: A match then deactivates the output
// RL5: if B above A, roles swap; never equal
// RL6: no new trigger edge during a pulse
// RL7: no new software trigger during a pulse
// RL8: both compare values nonzero before one-shot use
// RL9: counter runs as soon as mode leaves stop
// RL10: first match may slip one count clock
// RL11: compare contents undefined after timer stop
// RL12: change edge selection only while stopped
// RL13: external trigger stays live in software one-shot
// RL14: all-ones compare A: wrap sets overflow flag
// RL15: clear before next count is overridden
// RL16: capture beats concurrent read; read undefined
// RL17: one-shot only in free-run or edge-clear modes
// RL18: trigger as count clock blocks its captures
// RL19: capture pulse longer than two count clocks
// RL20: capture on fall, request on next rise
// RL21: high pin detected rising only at first enable
// RL22: two-sample filter; sampling clock depends on use
`timescale 1ns/1ps
module opct_top
	import opct_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic trigger_capture_input_a,
	input wire logic trigger_capture_input_b,
	output logic pulse_output_pin,
	input wire logic [1:0] op_mode,
	input wire logic [1:0] edge_select_a,
	input wire logic [1:0] edge_select_b,
	input wire logic [1:0] count_src_sel,
	input wire logic count_src_ext,
	input wire logic capture_a_en,
	input wire logic capture_b_en,
	input wire logic out_enable,
	input wire logic out_active_low,
	input wire logic oneshot_en,
	input wire logic software_oneshot_trigger,
	input wire logic compare_a_wr,
	input wire logic [15:0] compare_a_wdata,
	input wire logic compare_b_wr,
	input wire logic [15:0] compare_b_wdata,
	input wire logic compare_a_rd,
	input wire logic compare_b_rd,
	output logic [15:0] compare_a_rdata,
	output logic [15:0] compare_b_rdata,
	output logic [15:0] main_counter,
	output logic overflow_flag,
	input wire logic overflow_clr,
	output logic match_irq_a,
	output logic match_irq_b
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	opct_mode_e mode;
	opct_os_e os_state_r;
	opct_os_e os_state_nxt;
	opct_cnt_t cnt_r;
	opct_cnt_t compare_reg_a_r;
	opct_cnt_t compare_reg_b_r;
	opct_cnt_t cnt_out_r;
	opct_cnt_t rdata_a_r;
	opct_cnt_t rdata_b_r;
	logic ovf_r;
	logic ovf_hold_r;
	logic pin_r;
	logic irq_a_r;
	logic irq_b_r;
	logic cap_pend_a_r;
	logic cap_pend_b_r;
	logic irq_pend_a_r;
	logic irq_pend_b_r;

	logic run;
	logic presc_rise;
	logic presc_fall;
	logic edge_a;
	logic edge_b;
	logic cnt_tick;
	logic os_allowed;
	logic restart;
	logic wrap;
	logic match_a;
	logic match_b;
	logic b_first;
	logic on_match;
	logic off_match;
	logic pulse_level;
	logic cap_a_now;
	logic cap_b_now;
	logic cap_trig_a_ok;

	assign mode = opct_mode_e'(op_mode);
	assign run = (mode != MODE_STOP); // RL9

	// ---------------------------------------------------------------
	// count clock and trigger inputs
	// ---------------------------------------------------------------
	opct_edge_if eif_a ();
	opct_edge_if eif_b ();

	opct_prescaler u_presc (
		.mclk(mclk),
		.rstn(rstn),
		.run(run),
		.src_sel(count_src_sel),
		.rise(presc_rise),
		.fall(presc_fall)
	);

	// as count clock the pin is sampled every mclk, as a trigger at the count clock
	assign eif_a.pin = trigger_capture_input_a;
	assign eif_a.sample_en = count_src_ext ? 1'b1 : presc_rise; // RL22
	assign eif_a.run = run;
	assign eif_a.edge_sel = edge_select_a; // RL2
	assign eif_b.pin = trigger_capture_input_b;
	assign eif_b.sample_en = presc_rise; // RL22
	assign eif_b.run = run;
	assign eif_b.edge_sel = edge_select_b;

	// edge selection is taken live; a change while running applies from the next accepted level change
	opct_edge_filter u_filt_a (
		.mclk(mclk),
		.rstn(rstn),
		.eif(eif_a)
	); // RL21

	opct_edge_filter u_filt_b (
		.mclk(mclk),
		.rstn(rstn),
		.eif(eif_b)
	);

	assign edge_a = eif_a.valid_edge;
	assign edge_b = eif_b.valid_edge;

	// ---------------------------------------------------------------
	// counter
	// ---------------------------------------------------------------
	// counting starts with the divider, held at zero while stopped, so the first tick comes at once
	assign cnt_tick = run && (count_src_ext ? edge_a : presc_rise); // RL10
	assign os_allowed = oneshot_en && (mode == MODE_FREE || mode == MODE_EDGE_CLR); // RL17

	// the pin trigger stays live even when the software trigger is in use
	assign restart = run && ((edge_a && !count_src_ext
			&& (mode == MODE_EDGE_CLR || os_allowed)) // RL1 RL13
		|| (software_oneshot_trigger && os_allowed));

	assign match_a = cnt_tick && (cnt_r == compare_reg_a_r);
	assign match_b = cnt_tick && (cnt_r == compare_reg_b_r);

	// match-clear mode only wraps when compare A holds all ones
	assign wrap = cnt_tick && !restart && (cnt_r == CNT_MAX)
		&& (mode != MODE_MATCH_CLR || compare_reg_a_r == CNT_MAX); // RL14

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cnt_r <= CNT_ZERO;
		end else if (!run || restart) begin
			cnt_r <= CNT_ZERO; // RL3
		end else if (cnt_tick) begin
			if (mode == MODE_MATCH_CLR && cnt_r == compare_reg_a_r) begin
				cnt_r <= CNT_ZERO;
			end else begin
				cnt_r <= cnt_r + CNT_ONE;
			end
		end
	end

	// ---------------------------------------------------------------
	// overflow flag
	// ---------------------------------------------------------------
	// hold covers the window between the wrap and the count reaching one
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ovf_hold_r <= 1'b0;
		end else if (wrap) begin
			ovf_hold_r <= 1'b1;
		end else if (!run || cnt_tick || restart) begin
			ovf_hold_r <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ovf_r <= 1'b0;
		end else if (wrap || ovf_hold_r) begin
			ovf_r <= 1'b1; // RL14 RL15
		end else if (overflow_clr) begin
			ovf_r <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// one-shot sequencing
	// ---------------------------------------------------------------
	// the smaller compare value opens the pulse, the larger one closes it
	assign b_first = (compare_reg_b_r < compare_reg_a_r);
	assign on_match = b_first ? match_b : match_a; // RL3 RL5
	assign off_match = b_first ? match_a : match_b; // RL4 RL5

	always_comb begin
		os_state_nxt = os_state_r;
		case (os_state_r)
			OS_IDLE: begin
				os_state_nxt = OS_IDLE;
			end
			OS_WAIT: begin
				if (on_match) begin
					os_state_nxt = OS_PULSE;
				end
			end
			OS_PULSE: begin
				if (off_match) begin
					os_state_nxt = OS_IDLE;
				end
			end
			default: begin
				os_state_nxt = OS_IDLE;
			end
		endcase
		// a retrigger mid-pulse restarts the sequence; the source should not do this
		if (restart && os_allowed) begin
			os_state_nxt = OS_WAIT; // RL1 RL6 RL7
		end
		if (!os_allowed) begin
			os_state_nxt = OS_IDLE;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			os_state_r <= OS_IDLE;
		end else begin
			os_state_r <= os_state_nxt;
		end
	end

	// ---------------------------------------------------------------
	// pulse output pin
	// ---------------------------------------------------------------
	assign pulse_level = (os_state_r == OS_PULSE);

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pin_r <= 1'b0;
		end else begin
			pin_r <= out_enable && (pulse_level ^ out_active_low);
		end
	end

	// ---------------------------------------------------------------
	// capture and compare registers
	// ---------------------------------------------------------------
	// pin A as count clock cannot also serve as a capture trigger
	assign cap_trig_a_ok = !count_src_ext; // RL18
	assign cap_a_now = capture_a_en && cap_pend_a_r && presc_fall; // RL20
	assign cap_b_now = capture_b_en && cap_pend_b_r && presc_fall; // RL20

	// register A captures on pin B edges, register B on pin A edges
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cap_pend_a_r <= 1'b0;
			cap_pend_b_r <= 1'b0;
		end else begin
			if (edge_b && capture_a_en && run) begin
				cap_pend_a_r <= 1'b1;
			end else if (presc_fall || !run || !capture_a_en) begin
				cap_pend_a_r <= 1'b0;
			end
			if (edge_a && capture_b_en && cap_trig_a_ok && run) begin
				cap_pend_b_r <= 1'b1; // RL18
			end else if (presc_fall || !run || !capture_b_en) begin
				cap_pend_b_r <= 1'b0;
			end
		end
	end

	// contents are left as they stand when the timer stops; no retention is promised
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			compare_reg_a_r <= CNT_ZERO;
		end else if (cap_a_now) begin
			compare_reg_a_r <= cnt_r; // RL16
		end else if (compare_a_wr) begin
			compare_reg_a_r <= compare_a_wdata; // RL11
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			compare_reg_b_r <= CNT_ZERO;
		end else if (cap_b_now) begin
			compare_reg_b_r <= cnt_r; // RL16
		end else if (compare_b_wr) begin
			compare_reg_b_r <= compare_b_wdata; // RL11
		end
	end

	// a read that meets a capture returns the old word, which software must discard
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rdata_a_r <= CNT_ZERO;
			rdata_b_r <= CNT_ZERO;
		end else begin
			if (compare_a_rd) begin
				rdata_a_r <= compare_reg_a_r; // RL16
			end
			if (compare_b_rd) begin
				rdata_b_r <= compare_reg_b_r; // RL16
			end
		end
	end

	// ---------------------------------------------------------------
	// match and capture requests
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			irq_pend_a_r <= 1'b0;
			irq_pend_b_r <= 1'b0;
		end else begin
			if (cap_a_now) begin
				irq_pend_a_r <= 1'b1;
			end else if (presc_rise || !run) begin
				irq_pend_a_r <= 1'b0;
			end
			if (cap_b_now) begin
				irq_pend_b_r <= 1'b1;
			end else if (presc_rise || !run) begin
				irq_pend_b_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			irq_a_r <= 1'b0;
			irq_b_r <= 1'b0;
		end else begin
			irq_a_r <= (!capture_a_en && match_a) || (irq_pend_a_r && presc_rise); // RL20
			irq_b_r <= (!capture_b_en && match_b) || (irq_pend_b_r && presc_rise); // RL20
		end
	end

	// ---------------------------------------------------------------
	// registered status outputs
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cnt_out_r <= CNT_ZERO;
		end else begin
			cnt_out_r <= cnt_r;
		end
	end

	assign pulse_output_pin = pin_r;
	assign compare_a_rdata = rdata_a_r;
	assign compare_b_rdata = rdata_b_r;
	assign main_counter = cnt_out_r;
	assign overflow_flag = ovf_r;
	assign match_irq_a = irq_a_r;
	assign match_irq_b = irq_b_r;

endmodule

// ==== test/opct_top_checker.sv ====
// port-level assertions for the one-shot pulse / capture timer
// assumes a single mclk domain and is bound into every opct_top
`timescale 1ns/1ps
module opct_top_checker
	import opct_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [1:0] op_mode,
	input wire logic count_src_ext,
	input wire logic capture_a_en,
	input wire logic capture_b_en,
	input wire logic out_enable,
	input wire logic out_active_low,
	input wire logic compare_a_wr,
	input wire logic [15:0] compare_a_wdata,
	input wire logic compare_a_rd,
	input wire logic [15:0] compare_a_rdata,
	input wire logic pulse_output_pin,
	input wire logic [15:0] main_counter,
	input wire logic overflow_flag,
	input wire logic overflow_clr,
	input wire logic match_irq_a,
	input wire logic match_irq_b
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rstn);

	start_runs_a: assert property (
		op_mode != 2'h0 && $past(op_mode) == 2'h0 && !count_src_ext
		|-> ##[1:4] main_counter != 16'h0000) else $error("counter idle after start");
	stop_clears_a: assert property (
		op_mode == 2'h0 ##1 op_mode == 2'h0 |=> main_counter == 16'h0000)
		else $error("counter kept while stopped");
	no_pulse_match_a: assert property (
		(op_mode == 2'h3 && out_enable && !out_active_low) [*4] |-> !pulse_output_pin)
		else $error("pulse in match-clear mode");
	out_disabled_a: assert property (
		!out_enable [*2] |=> !pulse_output_pin) else $error("pulse pin driven while disabled");
	ovf_wrap_a: assert property (
		$rose(overflow_flag) |-> main_counter == 16'hffff || main_counter == 16'h0000)
		else $error("overflow away from wrap");
	ovf_sticky_a: assert property (
		overflow_flag && !overflow_clr ##1 op_mode != 2'h0 |-> overflow_flag)
		else $error("overflow flag dropped");
	ovf_clear_a: assert property (
		overflow_flag && overflow_clr && main_counter > 16'h0002 && main_counter < 16'hfff0
		|=> !overflow_flag) else $error("overflow clear ignored");
	irq_b_single_a: assert property (
		match_irq_b |=> !match_irq_b) else $error("irq b longer than one cycle");
	irq_a_single_a: assert property (
		$rose(match_irq_a) |=> $fell(match_irq_a)) else $error("irq a longer than one cycle");
	ext_no_capture_a: assert property (
		(count_src_ext && capture_b_en) [*8] |-> !match_irq_b)
		else $error("capture while pin is count clock");
	read_back_a: assert property (
		compare_a_wr && !capture_a_en ##2 compare_a_rd
		|=> compare_a_rdata == $past(compare_a_wdata, 3)) else $error("reg a read back wrong");
	ovf_hold_a: assert property (
		$rose(overflow_flag) && overflow_clr |=> overflow_flag)
		else $error("overflow clear not overridden");
endmodule

bind opct_top opct_top_checker chk_u (.mclk, .rstn, .op_mode, .count_src_ext, .capture_a_en,
	.capture_b_en, .out_enable, .out_active_low, .compare_a_wr, .compare_a_wdata,
	.compare_a_rd, .compare_a_rdata, .pulse_output_pin, .main_counter, .overflow_flag,
	.overflow_clr, .match_irq_a, .match_irq_b);

// ==== test/opct_trig_src.sv ====
// far side of the timer: the trigger source on pin a
// assumes the bench holds each level far longer than the filter's sampling
`timescale 1ns/1ps
module opct_trig_src (
	input wire logic req,
	input wire logic slow,
	output logic pin
);
	initial pin = 1'h0;
	// a slow source lands the edge a few mclk cycles late, off the clock phase
	always @(req) begin
		if (slow) pin <= #37 req;
		else pin <= #3 req;
	end
endmodule

// ==== test/test_oneshot_pulse_capture_timer.sv ====
// self-checking bench for the one-shot pulse / capture timer, mclk at 100 MHz
// assumes the package, the design and the trigger source model compile first
`timescale 1ns/1ps
module test_oneshot_pulse_capture_timer
	import opct_pkg::*;
;
	logic mclk = 1'h0, rstn = 1'h0, req = 1'h0, slow = 1'h0, pin_a;
	logic [1:0] op_mode = 2'h0, edge_a = 2'h2, src = 2'h0;
	logic ext = 1'h0, cap_b = 1'h0, oe = 1'h0, alow = 1'h0, os_en = 1'h0;
	logic sw = 1'h0, clr = 1'h0, a_wr = 1'h0, b_wr = 1'h0, a_rd = 1'h0, b_rd = 1'h0;
	logic [15:0] wdata = 16'h0000;
	logic [15:0] a_rdata, b_rdata, cnt;
	logic pulse, flag, irq_a, irq_b;
	int num_errors = 0, cmp_count = 0, t, on, off, k;

	always #5 mclk = ~mclk;

	opct_trig_src src_u (.req(req), .slow(slow), .pin(pin_a));
	opct_top dut_u (.mclk(mclk), .rstn(rstn), .trigger_capture_input_a(pin_a),
		.trigger_capture_input_b(1'h0), .pulse_output_pin(pulse), .op_mode(op_mode),
		.edge_select_a(edge_a), .edge_select_b(2'h2), .count_src_sel(src),
		.count_src_ext(ext), .capture_a_en(1'h0), .capture_b_en(cap_b), .out_enable(oe),
		.out_active_low(alow), .oneshot_en(os_en), .software_oneshot_trigger(sw),
		.compare_a_wr(a_wr), .compare_a_wdata(wdata), .compare_b_wr(b_wr),
		.compare_b_wdata(wdata), .compare_a_rd(a_rd), .compare_b_rd(b_rd),
		.compare_a_rdata(a_rdata), .compare_b_rdata(b_rdata), .main_counter(cnt),
		.overflow_flag(flag), .overflow_clr(clr), .match_irq_a(irq_a), .match_irq_b(irq_b));

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic finish_test();
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// 0: pulse in its active sense, 1: capture/match request b, 3: match request a, else overflow
	function automatic logic sig(input int s);
		case (s)
			0: return pulse ^ alow;
			1: return irq_b;
			3: return irq_a;
			default: return flag;
		endcase
	endfunction

	task automatic watch(input int s, input logic lvl, input int n, input bit must,
		output int tw);
		tw = -1;
		for (int i = 0; i < n && tw < 0; i++) begin
			@(posedge mclk);
			#1;
			if (sig(s) === lvl) tw = i;
		end
		if (must && tw < 0) begin
			chk("wait", 16'(s), 16'hffff);
			finish_test();
		end
	endtask

	task automatic wr(input bit b, input logic [15:0] v);
		@(posedge mclk);
		wdata <= v;
		a_wr <= !b;
		b_wr <= b;
		@(posedge mclk);
		a_wr <= 1'h0;
		b_wr <= 1'h0;
	endtask

	task automatic rd(input bit b);
		@(posedge mclk);
		a_rd <= !b;
		b_rd <= b;
		@(posedge mclk);
		a_rd <= 1'h0;
		b_rd <= 1'h0;
		#1;
	endtask

	task automatic strobe(input bit c);
		@(posedge mclk);
		sw <= !c;
		clr <= c;
		@(posedge mclk);
		sw <= 1'h0;
		clr <= 1'h0;
		#1;
	endtask

	task automatic drive_pin(input logic v);
		@(posedge mclk);
		req <= v;
	endtask

	// edge selection only moves while stopped
	task automatic setup(input logic [1:0] m, input logic [1:0] s, input opct_edge_e e,
		input int a, input int b);
		@(posedge mclk);
		op_mode <= 2'h0;
		src <= s;
		edge_a <= e;
		wr(0, 16'(a));
		wr(1, 16'(b));
		@(posedge mclk);
		op_mode <= m;
	endtask

	task automatic expect_pulse(input int lo, input int hi, input int w);
		int t0;
		int t1;
		watch(0, 1'h1, hi + 2, 1'h1, t0);
		chk("pulse start", 16'h0001, 16'(t0 >= lo && t0 <= hi));
		watch(0, 1'h0, 4000, 1'h1, t1);
		chk("pulse width", 16'(w), 16'(t1 + 1));
	endtask

	task automatic expect_capture();
		logic [15:0] c;
		watch(1, 1'h1, 40, 1'h1, t);
		c = cnt;
		rd(1);
		chk("capture b", 16'h0001, 16'(b_rdata <= c && b_rdata + 16'h0004 >= c));
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	initial begin
		void'($urandom(32'h0000_a751));
		cyc(2);
		rstn <= 1'h1;
		#1;
		chk("counter", 16'h0000, cnt); // RESET
		chk("pulse", 16'h0000, 16'(pulse)); // RESET
		on = $urandom % 65535 + 1;
		wr(0, 16'(on));
		rd(0);
		chk("reg a", 16'(on), a_rdata);
		// pin already high at the first start: one rising edge, none at restart
		drive_pin(1'h1);
		cap_b <= 1'h1;
		setup(2'h2, 2'h0, EDGE_RISE, 100, 200);
		expect_capture();
		setup(2'h2, 2'h0, EDGE_RISE, 100, 200);
		watch(1, 1'h1, 30, 1'h0, t);
		chk("restart edge", 16'hffff, 16'(t));
		drive_pin(1'h0);
		cyc(12);
		drive_pin(1'h1);
		expect_capture();
		drive_pin(1'h0);
		ext <= 1'h1;
		cyc(12);
		setup(2'h2, 2'h0, EDGE_RISE, 100, 200);
		repeat (2) begin
			drive_pin(1'h1);
			cyc(12);
			drive_pin(1'h0);
			cyc(12);
		end
		chk("edge count", 16'h0002, cnt);
		ext <= 1'h0;
		cap_b <= 1'h0;
		oe <= 1'h1;
		os_en <= 1'h1;
		for (int i = 0; i < 8; i++) begin
			on = 1 + $urandom % 20;
			off = on + 1 + $urandom % 20;
			k = 1 << (i % 4);
			@(posedge mclk);
			alow <= 1'(i / 4);
			if (i % 2 == 1) setup(2'h1, 2'(i % 4), EDGE_NONE, off, on);
			else setup(2'h2, 2'(i % 4), EDGE_NONE, on, off);
			cyc(4);
			strobe(0);
			expect_pulse((on - 1) * k, on * k + k + 8, (off - on) * k);
		end
		@(posedge mclk);
		alow <= 1'h0;
		for (int e = 0; e < 4; e++) begin
			on = 1 + $urandom % 20;
			off = on + 1 + $urandom % 20;
			drive_pin(e == 0);
			slow <= 1'(e % 2);
			cyc(12);
			setup((e == 1) ? 2'h2 : 2'h1, 2'h0, opct_edge_e'(e), off, on);
			cyc(12);
			drive_pin(e != 0);
			if (e == 2) begin
				watch(0, 1'h1, 100, 1'h0, t);
				chk("no edge", 16'hffff, 16'(t));
			end else begin
				expect_pulse(on - 1, on + 24, off - on);
			end
		end
		setup(2'h3, 2'h0, EDGE_NONE, 30, 10);
		cyc(4);
		strobe(0);
		watch(0, 1'h1, 100, 1'h0, t);
		chk("no pulse", 16'hffff, 16'(t));
		// match-clear with A at 30 repeats every 31 counts, so requests come 31 edges apart
		watch(3, 1'h1, 40, 1'h1, t);
		watch(3, 1'h1, 40, 1'h1, t);
		chk("match period", 16'h001e, 16'(t));
		os_en <= 1'h0;
		setup(2'h2, 2'h0, EDGE_NONE, 65535, 100);
		// clear held across the wrap: it must lose until the count reaches one
		clr <= 1'h1;
		watch(2, 1'h1, 70000, 1'h1, t);
		chk("wrap time", 16'h0001, 16'(t >= 65530 && t <= 65545));
		@(posedge mclk);
		#1;
		chk("flag held", 16'h0001, 16'(flag));
		@(posedge mclk);
		clr <= 1'h0;
		#1;
		chk("flag cleared", 16'h0000, 16'(flag));
		cyc(10);
		strobe(1);
		chk("flag clear", 16'h0000, 16'(flag));
		finish_test();
	end
endmodule
